/* File: test/gtm_core_checker.sv */
// Concurrent checks on the ports of the general timer core.
// Assumes one bus clock and a synchronous active-high reset; bound onto the core below.
`timescale 1ns/100ps
module gtm_core_checker #(
  parameter int CNT_W = gtm_pkg::CNT_W
) (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic [gtm_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [gtm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic [gtm_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       channel0_pin,
  input wire logic                       channel1_pin,
  input wire logic [3:0]                 internal_timer_input,
  input wire logic [CNT_W-1:0]           counter_value,
  input wire logic                       count_dir,
  input wire gtm_pkg::gtm_evt_t          timer_events
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence req_start_s; $rose(avs_read | avs_write); endsequence
  sequence one_wait_s; avs_waitrequest ##1 !avs_waitrequest; endsequence

  bus_wait_a: assert property (req_start_s |-> one_wait_s)
    else $error("bus request not answered after one wait cycle");
  idle_ready_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  up_wrap_a: assert property (timer_events.update && !count_dir |-> counter_value == '0)
    else $error("upward update not at counter zero");
  // Writes are excluded because they may load any value; reinitialisation while counting up loads zero and fails the nonzero test.
  count_step_a: assert property (!count_dir && $past(!count_dir) && !$past(avs_write)
    && $changed(counter_value) && counter_value != '0 && !timer_events.update
    |-> counter_value == $past(counter_value) + 1'b1)
    else $error("upward count skipped a value");
  trig_single_a: assert property (timer_events.trigger |=> !timer_events.trigger)
    else $error("trigger pulse longer than one cycle");
  upd_flag_a: assert property (timer_events.update |-> ##[0:1] timer_events.update_flag)
    else $error("update pulse without update flag");
  trig_flag_a: assert property (timer_events.trigger |-> ##[0:1] timer_events.trigger_flag)
    else $error("trigger pulse without trigger flag");
  upd_sticky_a: assert property (timer_events.update_flag && !avs_write
    |=> timer_events.update_flag)
    else $error("update flag dropped without a write");
  trig_sticky_a: assert property (timer_events.trigger_flag && !avs_write
    |=> timer_events.trigger_flag)
    else $error("trigger flag dropped without a write");
endmodule // gtm_core_checker

bind gtm_timer_core gtm_core_checker #(.CNT_W(CNT_W)) u_chk (.*);

/* File: test/gtm_trig_src.sv */
// Model of the far side: channel pins and trigger lines from other timers.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module gtm_trig_src (
  input  wire logic clk,
  output logic      channel0_pin,
  output logic      channel1_pin,
  output logic [3:0] internal_timer_input
);
  logic [5:0] line_reg;

  initial line_reg = 6'h00;
  assign {internal_timer_input, channel1_pin, channel0_pin} = line_reg;

  task automatic set_line(input int idx, input logic v);
    @(posedge clk);
    line_reg[idx] <= v;
  endtask

  // Width is chosen by the caller, so prompt and slow sources are both exercised.
  task automatic pulse(input int idx, input int hi);
    set_line(idx, 1'b1);
    repeat (hi) @(posedge clk);
    line_reg[idx] <= 1'b0;
  endtask

  // Four spaced transitions; the spacing leaves room for the synchroniser.
  task automatic quad(input logic fwd);
    for (int i = 0; i < 4; i++) begin
      set_line(fwd ? i % 2 : 1 - i % 2, i < 2);
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // gtm_trig_src

/* File: test/timer_counter_slave_control_test.sv */
// Self-checking bench for the general timer core: bus tasks and directed scenarios.
// Assumes the trigger source model drives the pins and the checker is bound to the core.
`timescale 1ns/100ps
module timer_counter_slave_control_test;
  logic              clk;
  logic              sys_rst;
  logic [4:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              channel0_pin;
  logic              channel1_pin;
  logic [3:0]        internal_timer_input;
  logic [15:0]       counter_value;
  logic              count_dir;
  gtm_pkg::gtm_evt_t timer_events;
  logic [31:0]       q;
  logic [15:0]       c1;
  int                err_total;
  int                cmp_count;

  gtm_timer_core DUT (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .channel0_pin(channel0_pin), .channel1_pin(channel1_pin),
    .internal_timer_input(internal_timer_input), .counter_value(counter_value),
    .count_dir(count_dir), .timer_events(timer_events));

  gtm_trig_src SRC (.clk(clk), .channel0_pin(channel0_pin), .channel1_pin(channel1_pin),
    .internal_timer_input(internal_timer_input));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge, before the design updates them.
  // Only the watchdog ends a wait that never gets its answer.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask

  // Cycles between two update pulses.
  task automatic period(input string nm, input int exp);
    int n;
    n = 0;
    do @(negedge clk); while (timer_events.update !== 1'b1 && ++n < 300);
    n = 0;
    do begin @(negedge clk); n++; end while (timer_events.update !== 1'b1 && n < 300);
    chk(nm, exp, n);
  endtask

  function automatic logic [31:0] cfg(input logic en, input logic dir, input logic [1:0] cms,
                                      input logic ud);
    return {23'h0, ud, 2'h0, cms, 2'h0, dir, en};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4));
      chk("reset value", (i == 4) ? 32'h0000_FFFF : 32'h0, q);
    end
    rd(5'h1D);
    chk("unmapped read", 32'h0, q);
    wr(gtm_pkg::OFF_RELOAD, 32'h3);
    wr(gtm_pkg::OFF_PSC, 32'h1);
    wr(gtm_pkg::OFF_EVG, 32'h1);
    wr(gtm_pkg::OFF_CNTCFG, cfg(1, 0, 0, 0));
    period("up period", 8);
    wr(gtm_pkg::OFF_CNTCFG, cfg(0, 0, 0, 0));
    wr(gtm_pkg::OFF_CNT, 32'h5);
    wr(gtm_pkg::OFF_EVG, 32'h1);
    @(negedge clk);
    chk("up soft update", 32'h0, counter_value);
    rd(gtm_pkg::OFF_INTST);
    chk("update flag", 32'h1, q);
    wr(gtm_pkg::OFF_INTST, 32'h1);
    rd(gtm_pkg::OFF_INTST);
    chk("flag cleared", 32'h0, q);
    wr(gtm_pkg::OFF_CNTCFG, cfg(0, 1, 0, 0));
    wr(gtm_pkg::OFF_EVG, 32'h1);
    @(negedge clk);
    chk("down soft update", 32'h3, counter_value);
    wr(gtm_pkg::OFF_CNTCFG, cfg(1, 1, 0, 0));
    period("down period", 8);
    wr(gtm_pkg::OFF_PSC, 32'h0);
    wr(gtm_pkg::OFF_EVG, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(gtm_pkg::OFF_CNTCFG, cfg(1, 0, 2'(m), 0));
      period("center period", (m == 3) ? 3 : 6);
    end
    wr(gtm_pkg::OFF_CNTCFG, cfg(0, 1, 3, 0));
    wr(gtm_pkg::OFF_CNT, 32'h2);
    wr(gtm_pkg::OFF_EVG, 32'h1);
    @(negedge clk);
    chk("center soft update", 32'h0, counter_value);
    // Leaving center mode first lets the next write set the direction to up.
    wr(gtm_pkg::OFF_CNTCFG, cfg(0, 0, 0, 0));
    wr(gtm_pkg::OFF_RELOAD, 32'hFFFF);
    wr(gtm_pkg::OFF_MODE, 32'h4);
    for (int ts = 1; ts < 8; ts++) begin
      wr(gtm_pkg::OFF_TRIG, ts);
      wr(gtm_pkg::OFF_CNTCFG, cfg(1, 0, 0, ts == 7));
      wr(gtm_pkg::OFF_INTST, 32'h3);
      repeat (20) @(posedge clk);
      SRC.pulse((ts == 1 || ts == 3) ? 0 : (ts == 2 ? 1 : ts - 2), ts);
      repeat (4) @(negedge clk);
      rd(gtm_pkg::OFF_CNT);
      chk("restart count", 32'h1, {31'h0, q < 32'h10});
      rd(gtm_pkg::OFF_INTST);
      chk("restart flags", {30'h0, 1'b1, ts != 7}, q);
    end
    wr(gtm_pkg::OFF_MODE, 32'h5);
    wr(gtm_pkg::OFF_TRIG, 32'h2);
    repeat (8) @(negedge clk);
    c1 = counter_value;
    repeat (10) @(negedge clk);
    chk("pause low", c1, counter_value);
    SRC.set_line(1, 1'b1);
    repeat (6) @(negedge clk);
    c1 = counter_value;
    repeat (10) @(negedge clk);
    chk("pause high", c1 + 16'hA, counter_value);
    SRC.set_line(1, 1'b0);
    wr(gtm_pkg::OFF_MODE, 32'h6);
    wr(gtm_pkg::OFF_TRIG, 32'h4);
    wr(gtm_pkg::OFF_CNTCFG, cfg(0, 0, 0, 0));
    SRC.pulse(2, 2);
    repeat (6) @(negedge clk);
    rd(gtm_pkg::OFF_CNTCFG);
    chk("trigger resume", 32'h1, q & 32'h1);
    wr(gtm_pkg::OFF_MODE, 32'h7);
    wr(gtm_pkg::OFF_TRIG, 32'h5);
    @(negedge clk);
    c1 = counter_value;
    repeat (3) begin
      SRC.pulse(3, 2);
      repeat (3) @(posedge clk);
    end
    repeat (6) @(negedge clk);
    chk("event count", c1 + 16'h3, counter_value);
    wr(gtm_pkg::OFF_TRIG, 32'h0);
    wr(gtm_pkg::OFF_CNT, 32'h9);
    wr(gtm_pkg::OFF_EVG, 32'h1);
    @(negedge clk);
    chk("event soft update", 32'h0, counter_value);
    wr(gtm_pkg::OFF_MODE, 32'h3);
    wr(gtm_pkg::OFF_CNT, 32'hA);
    SRC.quad(1'b1);
    repeat (6) @(negedge clk);
    chk("quad forward", {16'h0, 16'hE}, {count_dir, counter_value});
    SRC.quad(1'b0);
    repeat (6) @(negedge clk);
    chk("quad reverse", {16'h1, 16'hA}, {count_dir, counter_value});
    wr(gtm_pkg::OFF_MODE, 32'h1);
    SRC.quad(1'b1);
    repeat (6) @(negedge clk);
    chk("quad input0 only", {16'h0, 16'hC}, {count_dir, counter_value});
    wr(gtm_pkg::OFF_MODE, 32'h2);
    SRC.quad(1'b0);
    repeat (6) @(negedge clk);
    chk("quad input1 only", {16'h1, 16'hA}, {count_dir, counter_value});
    wr(gtm_pkg::OFF_CNTCFG, cfg(1, 0, 0, 0));
    @(negedge clk);
    chk("dir held by hardware", 32'h1, count_dir);
    summarize();
  end
endmodule // timer_counter_slave_control_test

/* File: verilog/gtm_pkg.sv */
// Package of the general timer: register map, field positions, modes and carriers.
// Assumes a single bus clock and an Avalon-MM slave port with byte addresses.
package gtm_pkg;

  localparam int CNT_W  = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int NPIN   = 6;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CNTCFG = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE   = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_TRIG   = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_PSC    = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_CNT    = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_EVG    = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_INTST  = 5'h1C;

  // Field positions.
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_DIR_BIT  = 1;
  localparam int CFG_CMS_LSB  = 4;
  localparam int CFG_UDIS_BIT = 8;
  localparam int MODE_SMS_LSB = 0;
  localparam int TRIG_TSEL_LSB = 0;
  localparam int EVG_UG_BIT   = 0;
  localparam int IST_UIF_BIT  = 0;
  localparam int IST_TIF_BIT  = 1;

  // Reset values.
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] PSC_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;

  typedef enum logic [1:0] {
    GTM_CMS_EDGE = 2'h0,
    GTM_CMS_UDF  = 2'h1,
    GTM_CMS_OVF  = 2'h2,
    GTM_CMS_BOTH = 2'h3
  } gtm_cms_t;

  typedef enum logic [2:0] {
    GTM_SM_OFF     = 3'h0,
    GTM_SM_QUAD0   = 3'h1,
    GTM_SM_QUAD1   = 3'h2,
    GTM_SM_QUAD01  = 3'h3,
    GTM_SM_RESTART = 3'h4,
    GTM_SM_PAUSE   = 3'h5,
    GTM_SM_TRIGGER = 3'h6,
    GTM_SM_EVENT   = 3'h7
  } gtm_sms_t;

  typedef enum logic [2:0] {
    GTM_TS_SOFT  = 3'h0,
    GTM_TS_CH0   = 3'h1,
    GTM_TS_CH1   = 3'h2,
    GTM_TS_CH0BE = 3'h3,
    GTM_TS_ITI0  = 3'h4,
    GTM_TS_ITI1  = 3'h5,
    GTM_TS_ITI2  = 3'h6,
    GTM_TS_ITI3  = 3'h7
  } gtm_tsel_t;

  // Software-visible configuration held by the core.
  typedef struct packed {
    logic             en;
    logic             udis;
    gtm_cms_t         cms;
    gtm_sms_t         sms;
    gtm_tsel_t        tsel;
    logic [CNT_W-1:0] psc;
    logic [CNT_W-1:0] reload;
  } gtm_cfg_t;

  // Timer events presented to the rest of the timer.
  typedef struct packed {
    logic update;
    logic trigger;
    logic update_flag;
    logic trigger_flag;
  } gtm_evt_t;

endpackage : gtm_pkg

/* File: verilog/gtm_timer_core.sv */
// Counter, prescaler, clock selection, trigger selection and slave controller of the
// general timer, with its Avalon-MM register slave. One bus clock drives everything;
// pins and inputs from other timers arrive asynchronously and are synchronised here.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps

module gtm_timer_core #(
  parameter int CNT_W = gtm_pkg::CNT_W
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [gtm_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [gtm_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [gtm_pkg::DATA_W-1:0]  avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        channel0_pin,
  input  wire logic                        channel1_pin,
  input  wire logic [3:0]                  internal_timer_input,
  output logic      [CNT_W-1:0]            counter_value,
  output logic                             count_dir,
  output gtm_pkg::gtm_evt_t                timer_events
);

  // ---------------------------------------------------------------- input sync
  logic [gtm_pkg::NPIN-1:0] pins;
  logic [gtm_pkg::NPIN-1:0] sync1_reg;
  logic [gtm_pkg::NPIN-1:0] sync2_reg;
  logic [gtm_pkg::NPIN-1:0] prev_reg;

  assign pins = {internal_timer_input, channel1_pin, channel0_pin};

  genvar gi;
  generate
    for (gi = 0; gi < gtm_pkg::NPIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------- bus handshake
  logic                       ack_reg;
  logic                       ack_next;
  logic [gtm_pkg::DATA_W-1:0] rdata_reg;
  logic [gtm_pkg::DATA_W-1:0] rdata_next;
  logic                       wr_go;

  // Every access waits exactly one cycle, so read data always comes from a flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign wr_go           = avs_write & ack_reg;

  function automatic logic [gtm_pkg::DATA_W-1:0] be_merge(
    input logic [gtm_pkg::DATA_W-1:0] old_v,
    input logic [gtm_pkg::DATA_W-1:0] new_v,
    input logic [3:0]                 be
  );
    logic [gtm_pkg::DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------- core state
  gtm_pkg::gtm_cfg_t cfg_reg;
  gtm_pkg::gtm_cfg_t cfg_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [CNT_W-1:0]  psc_cnt_reg;
  logic [CNT_W-1:0]  psc_cnt_next;
  logic [CNT_W-1:0]  psc_act_reg;
  logic [CNT_W-1:0]  psc_act_next;
  logic              dir_reg;
  logic              dir_next;
  logic              trig_prev_reg;
  logic              trig_prev_next;
  gtm_pkg::gtm_evt_t evt_reg;
  gtm_pkg::gtm_evt_t evt_next;

  assign counter_value = cnt_reg;
  assign count_dir     = dir_reg;
  assign timer_events  = evt_reg;

  // Register read mux.
  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = '0;
    if (avs_read) begin
      unique case (avs_address)
        gtm_pkg::OFF_CNTCFG: begin
          rdata_next[gtm_pkg::CFG_EN_BIT]                 = cfg_reg.en;
          rdata_next[gtm_pkg::CFG_DIR_BIT]                = dir_reg;
          rdata_next[gtm_pkg::CFG_CMS_LSB +: 2]           = cfg_reg.cms;
          rdata_next[gtm_pkg::CFG_UDIS_BIT]               = cfg_reg.udis;
        end
        gtm_pkg::OFF_MODE:   rdata_next[gtm_pkg::MODE_SMS_LSB +: 3]  = cfg_reg.sms;
        gtm_pkg::OFF_TRIG:   rdata_next[gtm_pkg::TRIG_TSEL_LSB +: 3] = cfg_reg.tsel;
        gtm_pkg::OFF_PSC:    rdata_next[CNT_W-1:0] = cfg_reg.psc;
        gtm_pkg::OFF_RELOAD: rdata_next[CNT_W-1:0] = cfg_reg.reload;
        gtm_pkg::OFF_CNT:    rdata_next[CNT_W-1:0] = cnt_reg;
        gtm_pkg::OFF_INTST: begin
          rdata_next[gtm_pkg::IST_UIF_BIT] = evt_reg.update_flag;
          rdata_next[gtm_pkg::IST_TIF_BIT] = evt_reg.trigger_flag;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------- timer core
  logic [gtm_pkg::DATA_W-1:0] wmerged;
  logic              sw_ug;
  logic              quad_mode;
  logic              center_mode;
  logic              trig_lvl;
  logic              trig_edge;
  logic              tick;
  logic              tick_dir;
  logic              q_up;
  logic              q_dn;
  logic              step;
  logic              ovf;
  logic              udf;
  logic              upd_req;
  logic              reinit;
  logic              upd_evt;
  logic              trig_evt;
  logic              run;
  logic              s0;
  logic              s1;
  logic              r0;
  logic              f0;
  logic              r1;
  logic              f1;

  always_comb begin
    cfg_next       = cfg_reg;
    cnt_next       = cnt_reg;
    psc_cnt_next   = psc_cnt_reg;
    psc_act_next   = psc_act_reg;
    dir_next       = dir_reg;
    evt_next       = evt_reg;
    wmerged        = '0;
    tick           = 1'b0;
    tick_dir       = dir_reg;
    q_up           = 1'b0;
    q_dn           = 1'b0;
    step           = 1'b0;
    ovf            = 1'b0;
    udf            = 1'b0;
    reinit         = 1'b0;
    upd_req        = 1'b0;
    trig_evt       = 1'b0;
    run            = cfg_reg.en;
    trig_lvl       = 1'b0;

    s0 = sync2_reg[0];
    s1 = sync2_reg[1];
    r0 = s0 & ~prev_reg[0];
    f0 = ~s0 & prev_reg[0];
    r1 = s1 & ~prev_reg[1];
    f1 = ~s1 & prev_reg[1];

    sw_ug = wr_go && avs_address == gtm_pkg::OFF_EVG && avs_byteenable[0]
            && avs_writedata[gtm_pkg::EVG_UG_BIT];
    quad_mode   = cfg_reg.sms inside {gtm_pkg::GTM_SM_QUAD0, gtm_pkg::GTM_SM_QUAD1,
                                      gtm_pkg::GTM_SM_QUAD01};
    center_mode = cfg_reg.cms != gtm_pkg::GTM_CMS_EDGE;

    // Trigger level mux; only the level path can see the software update bit.
    unique case (cfg_reg.tsel)
      gtm_pkg::GTM_TS_SOFT:  trig_lvl = sw_ug;
      gtm_pkg::GTM_TS_CH0:   trig_lvl = s0;
      gtm_pkg::GTM_TS_CH1:   trig_lvl = s1;
      gtm_pkg::GTM_TS_CH0BE: trig_lvl = r0 | f0;
      gtm_pkg::GTM_TS_ITI0:  trig_lvl = sync2_reg[2];
      gtm_pkg::GTM_TS_ITI1:  trig_lvl = sync2_reg[3];
      gtm_pkg::GTM_TS_ITI2:  trig_lvl = sync2_reg[4];
      gtm_pkg::GTM_TS_ITI3:  trig_lvl = sync2_reg[5];
    endcase
    trig_prev_next = trig_lvl;
    trig_edge = trig_lvl & ~trig_prev_reg & (cfg_reg.tsel != gtm_pkg::GTM_TS_SOFT);

    // Quadrature direction decoding per transition.
    if (cfg_reg.sms == gtm_pkg::GTM_SM_QUAD0 || cfg_reg.sms == gtm_pkg::GTM_SM_QUAD01) begin
      q_up = (r0 & ~s1) | (f0 & s1);
      q_dn = (r0 & s1) | (f0 & ~s1);
    end
    if (cfg_reg.sms == gtm_pkg::GTM_SM_QUAD1 || cfg_reg.sms == gtm_pkg::GTM_SM_QUAD01) begin
      q_up = q_up | (r1 & s0) | (f1 & ~s0);
      q_dn = q_dn | (r1 & ~s0) | (f1 & s0);
    end

    // Clock source selection for the prescaler.
    unique case (cfg_reg.sms)
      gtm_pkg::GTM_SM_OFF, gtm_pkg::GTM_SM_RESTART,
      gtm_pkg::GTM_SM_PAUSE, gtm_pkg::GTM_SM_TRIGGER: tick = 1'b1;
      gtm_pkg::GTM_SM_QUAD0, gtm_pkg::GTM_SM_QUAD1, gtm_pkg::GTM_SM_QUAD01: begin
        tick     = q_up | q_dn;
        tick_dir = q_dn;
      end
      gtm_pkg::GTM_SM_EVENT: tick = trig_edge;
    endcase

    if (cfg_reg.sms == gtm_pkg::GTM_SM_PAUSE) begin
      run = cfg_reg.en & trig_lvl;
    end

    if (quad_mode && tick) begin
      dir_next = tick_dir;
    end

    // Prescaler: divides by psc_act_reg plus one.
    if (run && tick) begin
      if (psc_cnt_reg >= psc_act_reg) begin
        psc_cnt_next = '0;
        step         = 1'b1;
      end else begin
        psc_cnt_next = psc_cnt_reg + 16'h0001;
      end
    end

    if (step) begin
      if (center_mode && !quad_mode) begin
        if (!dir_reg) begin
          cnt_next = (cnt_reg >= cfg_reg.reload) ? cfg_reg.reload : cnt_reg + 16'h0001;
          if (cnt_next == cfg_reg.reload) begin
            ovf      = 1'b1;
            dir_next = 1'b1;
          end
        end else begin
          cnt_next = (cnt_reg == '0) ? '0 : cnt_reg - 16'h0001;
          if (cnt_next == '0) begin
            udf      = 1'b1;
            dir_next = 1'b0;
          end
        end
      end else if (!tick_dir) begin
        if (cnt_reg >= cfg_reg.reload) begin
          cnt_next = '0;
          ovf      = 1'b1;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end else begin
        if (cnt_reg == '0) begin
          cnt_next = cfg_reg.reload;
          udf      = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
    end

    // Slave controller reactions to the trigger edge.
    if (trig_edge) begin
      unique case (cfg_reg.sms)
        gtm_pkg::GTM_SM_RESTART: begin
          trig_evt = 1'b1;
          upd_req  = 1'b1;
        end
        gtm_pkg::GTM_SM_TRIGGER: begin
          trig_evt = 1'b1;
          cfg_next.en = 1'b1;
        end
        gtm_pkg::GTM_SM_PAUSE: trig_evt = 1'b1;
        default: trig_evt = 1'b0;
      endcase
    end

    // Register writes; direction is only software-owned in plain edge modes.
    if (wr_go) begin
      unique case (avs_address)
        gtm_pkg::OFF_CNTCFG: begin
          wmerged = be_merge({23'h0, cfg_reg.udis, 2'h0, cfg_reg.cms, 2'h0, dir_reg,
                              cfg_reg.en}, avs_writedata, avs_byteenable);
          if (!(cfg_reg.sms == gtm_pkg::GTM_SM_TRIGGER && trig_edge)) begin
            cfg_next.en = wmerged[gtm_pkg::CFG_EN_BIT];
          end
          cfg_next.udis = wmerged[gtm_pkg::CFG_UDIS_BIT];
          cfg_next.cms  = gtm_pkg::gtm_cms_t'(wmerged[gtm_pkg::CFG_CMS_LSB +: 2]);
          if (!center_mode && !quad_mode) begin
            dir_next = wmerged[gtm_pkg::CFG_DIR_BIT];
          end
        end
        gtm_pkg::OFF_MODE: begin
          wmerged = be_merge({29'h0, cfg_reg.sms}, avs_writedata, avs_byteenable);
          cfg_next.sms = gtm_pkg::gtm_sms_t'(wmerged[gtm_pkg::MODE_SMS_LSB +: 3]);
        end
        gtm_pkg::OFF_TRIG: begin
          wmerged = be_merge({29'h0, cfg_reg.tsel}, avs_writedata, avs_byteenable);
          cfg_next.tsel = gtm_pkg::gtm_tsel_t'(wmerged[gtm_pkg::TRIG_TSEL_LSB +: 3]);
        end
        gtm_pkg::OFF_PSC: begin
          wmerged = be_merge({16'h0, cfg_reg.psc}, avs_writedata, avs_byteenable);
          cfg_next.psc = wmerged[CNT_W-1:0];
        end
        gtm_pkg::OFF_RELOAD: begin
          wmerged = be_merge({16'h0, cfg_reg.reload}, avs_writedata, avs_byteenable);
          cfg_next.reload = wmerged[CNT_W-1:0];
        end
        gtm_pkg::OFF_CNT: begin
          wmerged  = be_merge({16'h0, cnt_reg}, avs_writedata, avs_byteenable);
          cnt_next = wmerged[CNT_W-1:0];
        end
        default: wmerged = '0;
      endcase
    end

    if (sw_ug) begin
      upd_req = 1'b1;
    end

    // Reinitialisation always happens; the update event itself obeys the disable bit.
    reinit  = upd_req;
    upd_evt = ~cfg_reg.udis & (upd_req | ovf | udf);
    if (center_mode && !quad_mode && !upd_req) begin
      upd_evt = ~cfg_reg.udis &
                ((ovf & cfg_reg.cms[1]) | (udf & cfg_reg.cms[0]));
    end

    if (reinit) begin
      psc_cnt_next = '0;
      if (center_mode || !dir_next) begin
        cnt_next = '0;
      end else begin
        cnt_next = cfg_reg.reload;
      end
    end

    // The prescale ratio is preloaded and takes effect at the update event.
    if (upd_evt) begin
      psc_act_next = cfg_reg.psc;
    end

    // Set wins over a write-one clear in the same cycle.
    evt_next.update  = upd_evt;
    evt_next.trigger = trig_evt;
    if (wr_go && avs_address == gtm_pkg::OFF_INTST && avs_byteenable[0]) begin
      evt_next.update_flag  = evt_reg.update_flag & ~avs_writedata[gtm_pkg::IST_UIF_BIT];
      evt_next.trigger_flag = evt_reg.trigger_flag & ~avs_writedata[gtm_pkg::IST_TIF_BIT];
    end
    evt_next.update_flag  = evt_next.update_flag | upd_evt;
    evt_next.trigger_flag = evt_next.trigger_flag | trig_evt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg       <= '{en: 1'b0, udis: 1'b0, cms: gtm_pkg::GTM_CMS_EDGE,
                         sms: gtm_pkg::GTM_SM_OFF, tsel: gtm_pkg::GTM_TS_SOFT,
                         psc: gtm_pkg::PSC_RST, reload: gtm_pkg::RELOAD_RST};
      cnt_reg       <= gtm_pkg::CNT_RST;
      psc_cnt_reg   <= '0;
      psc_act_reg   <= gtm_pkg::PSC_RST;
      dir_reg       <= 1'b0;
      trig_prev_reg <= 1'b0;
      evt_reg       <= '0;
    end else begin
      cfg_reg       <= cfg_next;
      cnt_reg       <= cnt_next;
      psc_cnt_reg   <= psc_cnt_next;
      psc_act_reg   <= psc_act_next;
      dir_reg       <= dir_next;
      trig_prev_reg <= trig_prev_next;
      evt_reg       <= evt_next;
    end
  end

endmodule // gtm_timer_core
